// ==== rtl/port_alternate_function_mux.sv ====
// Functional notes
// - control bit set selects alternate function
// - control mode ignores latch and direction
// - p2.4-7: interrupt 110-113 or DMA count
// - mode reg three sets those edges
// - p3.0-3: serial ch2/uart or int 130-133
// - mode reg five sets 130-133 edges
// - p3.4: uart receive or interrupt 120
// - p3.5-7: interrupts 121-123, mode reg four
// - p3.7 shared by int 123 and trigger
// - trigger only in adc external mode
// - p4.0/1/3/4: serial or uart lines
// - p4.2/5: bidirectional serial clocks 0,1
// - p2.0 nmi input, p2.3 timer output
// - p2.1 feeds int 020 and capture
// - separate edge field for capture input
// - p2.2 routes interrupt 021 with edge
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ns
`include "pin_mux_defines.svh"
module port_alternate_function_mux
    import pin_mux_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // port configuration, written by software
    input wire port_cfg_type port2_cfg,
    input wire port_cfg_type port3_cfg,
    input wire port_cfg_type port4_cfg,
    // edge fields, passed on to the interrupt and timer units, and the converter mode used here
    input wire logic [7:0] irq_mode_reg_third,
    input wire logic [7:0] irq_mode_reg_fourth,
    input wire logic [7:0] irq_mode_reg_fifth,
    input wire logic [7:0] timer2_edge_select,
    input wire logic [1:0] adc_mode_reg,
    // pad inputs
    input wire logic [7:0] port2_pad_in,
    input wire logic [7:0] port3_pad_in,
    input wire logic [7:0] port4_pad_in,
    // peripheral outputs toward the pads
    input wire logic timer2_output,
    input wire logic [3:0] dma_terminal_count,
    input wire logic serial_out_ch2,
    input wire logic uart_transmit_ch2,
    input wire logic serial_clock_ch2_out,
    input wire logic serial_clock_ch2_oe,
    input wire logic serial_out_ch0,
    input wire logic uart_transmit_ch0,
    input wire logic serial_out_ch1,
    input wire logic uart_transmit_ch1,
    input wire logic [1:0] serial_clock_out,
    input wire logic [1:0] serial_clock_oe,
    // pad drive
    output pad_drive_type port2_pad,
    output pad_drive_type port3_pad,
    output pad_drive_type port4_pad,
    // general port read-back
    output logic [23:0] port_read_level,
    // peripheral inputs from the pads
    output logic nmi_in,
    output logic ext_irq_020,
    output logic timer2_capture_input,
    output logic ext_irq_021,
    output logic [3:0] ext_irq_11x,
    output logic [3:0] ext_irq_12x,
    output logic [3:0] ext_irq_13x,
    output logic adc_external_trigger,
    output logic serial_in_ch2,
    output logic serial_clock_ch2_in,
    output logic uart_receive_ch2,
    output logic serial_in_ch0,
    output logic uart_receive_ch0,
    output logic serial_in_ch1,
    output logic uart_receive_ch1,
    output logic [1:0] serial_clock_in,
    // edge fields forwarded, registered
    output logic [1:0] ext_irq_020_edge,
    output logic [1:0] timer2_capture_edge,
    output logic [1:0] ext_irq_021_edge,
    output logic [7:0] ext_irq_11x_edge,
    output logic [7:0] ext_irq_12x_edge,
    output logic [7:0] ext_irq_13x_edge
);

//////////////////////////////////////////////////////////////////////////////
// pad synchronisers
    logic [23:0] pad_sync;
    logic [7:0] p2_in;
    logic [7:0] p3_in;
    logic [7:0] p4_in;

    pin_sync u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .async_in({port4_pad_in, port3_pad_in, port2_pad_in}),
        .sync_out(pad_sync)
    );

    assign p2_in = pad_sync[7:0];
    assign p3_in = pad_sync[15:8];
    assign p4_in = pad_sync[23:16];

//////////////////////////////////////////////////////////////////////////////
// alternate output and enable per pin
    logic [7:0] p2_ctl;
    logic [7:0] p3_ctl;
    logic [7:0] p4_ctl;
    logic [7:0] p2_sel;
    logic [7:0] p3_sel;
    logic [7:0] p4_sel;
    logic [7:0] p2_alt_out;
    logic [7:0] p2_alt_oe;
    logic [7:0] p3_alt_out;
    logic [7:0] p3_alt_oe;
    logic [7:0] p4_alt_out;
    logic [7:0] p4_alt_oe;

    assign p2_ctl = port2_cfg.alt_function_enable;
    assign p3_ctl = port3_cfg.alt_function_enable;
    assign p4_ctl = port4_cfg.alt_function_enable;
    assign p2_sel = port2_cfg.function_select;
    assign p3_sel = port3_cfg.function_select;
    assign p4_sel = port4_cfg.function_select;

    always_comb begin
        p2_alt_out = 8'h00;
        p2_alt_oe = 8'h00;
        p2_alt_out[`P2_TIMER_OUT_PIN] = timer2_output;
        p2_alt_oe[`P2_TIMER_OUT_PIN] = 1'b1;
        p2_alt_out[7:4] = dma_terminal_count;
        p2_alt_oe[7:4] = p2_sel[7:4];
    end

    always_comb begin
        p3_alt_out = 8'h00;
        p3_alt_oe = 8'h00;
        p3_alt_out[`P3_SO2_PIN] = serial_out_ch2;
        p3_alt_oe[`P3_SO2_PIN] = ~p3_sel[`P3_SO2_PIN];
        p3_alt_out[`P3_SCK2_PIN] = serial_clock_ch2_out;
        p3_alt_oe[`P3_SCK2_PIN] = ~p3_sel[`P3_SCK2_PIN] & serial_clock_ch2_oe;
        p3_alt_out[`P3_TXD2_PIN] = uart_transmit_ch2;
        p3_alt_oe[`P3_TXD2_PIN] = ~p3_sel[`P3_TXD2_PIN];
    end

    always_comb begin
        p4_alt_out = 8'h00;
        p4_alt_oe = 8'h00;
        p4_alt_out[`P4_SO0_PIN] = p4_sel[`P4_SO0_PIN] ? uart_transmit_ch0 : serial_out_ch0;
        p4_alt_oe[`P4_SO0_PIN] = 1'b1;
        p4_alt_out[`P4_SO1_PIN] = p4_sel[`P4_SO1_PIN] ? uart_transmit_ch1 : serial_out_ch1;
        p4_alt_oe[`P4_SO1_PIN] = 1'b1;
        p4_alt_out[`P4_SERIAL_CLOCK_CH0_PIN] = serial_clock_out[0];
        p4_alt_oe[`P4_SERIAL_CLOCK_CH0_PIN] = serial_clock_oe[0];
        p4_alt_out[`P4_SCK1_PIN] = serial_clock_out[1];
        p4_alt_oe[`P4_SCK1_PIN] = serial_clock_oe[1];
    end

//////////////////////////////////////////////////////////////////////////////
// pad drive: control mode takes the peripheral, else latch and direction
    pad_drive_type p2_nxt;
    pad_drive_type p3_nxt;
    pad_drive_type p4_nxt;

    always_comb begin
        p2_nxt.pad_out = (p2_ctl & p2_alt_out) | (~p2_ctl & port2_cfg.out_latch);
        p2_nxt.pad_oe = (p2_ctl & p2_alt_oe) | (~p2_ctl & ~port2_cfg.pin_direction_bit);
        p3_nxt.pad_out = (p3_ctl & p3_alt_out) | (~p3_ctl & port3_cfg.out_latch);
        p3_nxt.pad_oe = (p3_ctl & p3_alt_oe) | (~p3_ctl & ~port3_cfg.pin_direction_bit);
        p4_nxt.pad_out = (p4_ctl & p4_alt_out) | (~p4_ctl & port4_cfg.out_latch);
        p4_nxt.pad_oe = (p4_ctl & p4_alt_oe) | (~p4_ctl & ~port4_cfg.pin_direction_bit);
    end

    // reset leaves every pad undriven, as general inputs
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            port2_pad <= 16'h0000;
            port3_pad <= 16'h0000;
            port4_pad <= 16'h0000;
            port_read_level <= 24'h00_0000;
        end else begin
            port2_pad <= p2_nxt;
            port3_pad <= p3_nxt;
            port4_pad <= p4_nxt;
            port_read_level <= pad_sync;
        end
    end

//////////////////////////////////////////////////////////////////////////////
// peripheral inputs: held low unless pin is selected for them
    logic adc_ext_mode;
    logic [3:0] p2_irq_route;
    logic [3:0] p3_irq_route;
    assign adc_ext_mode = (adc_mode_reg == `ADC_MODE_EXT_TRIGGER);
    assign p2_irq_route = p2_ctl[7:4] & ~p2_sel[7:4];
    assign p3_irq_route = p3_ctl[3:0] & p3_sel[3:0];

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            nmi_in <= 1'b0;
            ext_irq_020 <= 1'b0;
            timer2_capture_input <= 1'b0;
            ext_irq_021 <= 1'b0;
            ext_irq_11x <= 4'h0;
            ext_irq_12x <= 4'h0;
            ext_irq_13x <= 4'h0;
            adc_external_trigger <= 1'b0;
        end else begin
            nmi_in <= p2_ctl[`P2_NMI_PIN] & p2_in[`P2_NMI_PIN];
            ext_irq_020 <= p2_ctl[`P2_SHARED_TIMER_PIN] & p2_in[`P2_SHARED_TIMER_PIN];
            timer2_capture_input <= p2_ctl[`P2_SHARED_TIMER_PIN] & p2_in[`P2_SHARED_TIMER_PIN];
            ext_irq_021 <= p2_ctl[`P2_IRQ021_PIN] & p2_in[`P2_IRQ021_PIN];
            ext_irq_11x <= p2_irq_route & p2_in[7:4];
            ext_irq_13x <= p3_irq_route & p3_in[3:0];
            ext_irq_12x[0] <= p3_ctl[`P3_RXD2_PIN] & p3_sel[`P3_RXD2_PIN]
                & p3_in[`P3_RXD2_PIN];
            ext_irq_12x[2:1] <= p3_ctl[6:5] & p3_in[6:5];
            ext_irq_12x[3] <= p3_ctl[`P3_ADC_PIN] & ~adc_ext_mode & p3_in[`P3_ADC_PIN];
            adc_external_trigger <= p3_ctl[`P3_ADC_PIN] & adc_ext_mode & p3_in[`P3_ADC_PIN];
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            serial_in_ch2 <= 1'b0;
            serial_clock_ch2_in <= 1'b0;
            uart_receive_ch2 <= 1'b0;
            serial_in_ch0 <= 1'b0;
            uart_receive_ch0 <= 1'b0;
            serial_in_ch1 <= 1'b0;
            uart_receive_ch1 <= 1'b0;
            serial_clock_in <= 2'h0;
        end else begin
            serial_in_ch2 <= p3_ctl[`P3_SI2_PIN] & ~p3_sel[`P3_SI2_PIN]
                & p3_in[`P3_SI2_PIN];
            serial_clock_ch2_in <= p3_ctl[`P3_SCK2_PIN] & ~p3_sel[`P3_SCK2_PIN]
                & p3_in[`P3_SCK2_PIN];
            uart_receive_ch2 <= p3_ctl[`P3_RXD2_PIN] & ~p3_sel[`P3_RXD2_PIN]
                & p3_in[`P3_RXD2_PIN];
            serial_in_ch0 <= p4_ctl[`P4_SI0_PIN] & ~p4_sel[`P4_SI0_PIN]
                & p4_in[`P4_SI0_PIN];
            uart_receive_ch0 <= p4_ctl[`P4_SI0_PIN] & p4_sel[`P4_SI0_PIN] & p4_in[`P4_SI0_PIN];
            serial_in_ch1 <= p4_ctl[`P4_SI1_PIN] & ~p4_sel[`P4_SI1_PIN] & p4_in[`P4_SI1_PIN];
            uart_receive_ch1 <= p4_ctl[`P4_SI1_PIN] & p4_sel[`P4_SI1_PIN] & p4_in[`P4_SI1_PIN];
            serial_clock_in[0] <= p4_ctl[`P4_SERIAL_CLOCK_CH0_PIN] & p4_in[`P4_SERIAL_CLOCK_CH0_PIN];
            serial_clock_in[1] <= p4_ctl[`P4_SCK1_PIN] & p4_in[`P4_SCK1_PIN];
        end
    end

//////////////////////////////////////////////////////////////////////////////
// edge fields toward interrupt and timer units
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            ext_irq_020_edge <= 2'h0;
            timer2_capture_edge <= 2'h0;
            ext_irq_021_edge <= 2'h0;
            ext_irq_11x_edge <= 8'h00;
            ext_irq_12x_edge <= 8'h00;
            ext_irq_13x_edge <= 8'h00;
        end else begin
            ext_irq_020_edge <= timer2_edge_select[1:0];
            ext_irq_021_edge <= timer2_edge_select[3:2];
            timer2_capture_edge <= timer2_edge_select[5:4];
            ext_irq_11x_edge <= irq_mode_reg_third;
            ext_irq_12x_edge <= irq_mode_reg_fourth;
            ext_irq_13x_edge <= irq_mode_reg_fifth;
        end
    end

endmodule

// ==== rtl/pin_mux_defines.svh ====
`ifndef PIN_MUX_DEFINES_SVH
`define PIN_MUX_DEFINES_SVH

// pin positions, port 2
`define P2_NMI_PIN 0
`define P2_SHARED_TIMER_PIN 1
`define P2_IRQ021_PIN 2
`define P2_TIMER_OUT_PIN 3
`define P2_SELECT_LO 4
// pin positions, port 3
`define P3_SO2_PIN 0
`define P3_SI2_PIN 1
`define P3_SCK2_PIN 2
`define P3_TXD2_PIN 3
`define P3_RXD2_PIN 4
`define P3_ADC_PIN 7
// pin positions, port 4
`define P4_SO0_PIN 0
`define P4_SI0_PIN 1
`define P4_SERIAL_CLOCK_CH0_PIN 2
`define P4_SO1_PIN 3
`define P4_SI1_PIN 4
`define P4_SCK1_PIN 5
// reset values, and the converter external trigger mode code
`define PORT_CTRL_RESET 8'h00
`define FUNC_SEL_RESET 8'h00
`define ADC_MODE_EXT_TRIGGER 2'h3

`endif

// ==== rtl/pin_mux_pkg.sv ====
package pin_mux_pkg;

    typedef enum logic [1:0] {
        edge_none_type_val = 2'h0,
        edge_rise_type_val = 2'h1,
        edge_fall_type_val = 2'h2,
        edge_both_type_val = 2'h3
    } edge_sel_type;

    // per-port pin control set
    typedef struct packed {
        logic [7:0] alt_function_enable;
        logic [7:0] function_select;
        logic [7:0] pin_direction_bit;
        logic [7:0] out_latch;
    } port_cfg_type;

    // one port as seen by its pads: output, enable, one bit per pin
    typedef struct packed {
        logic [7:0] pad_out;
        logic [7:0] pad_oe;
    } pad_drive_type;

endpackage

// ==== rtl/pin_sync.sv ====
`timescale 1ns/1ns
module pin_sync (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // pin levels
    input wire logic [23:0] async_in,
    output logic [23:0] sync_out
);
    logic [23:0] stage1_r;

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            stage1_r <= 24'h00_0000;
            sync_out <= 24'h00_0000;
        end else begin
            stage1_r <= async_in;
            sync_out <= stage1_r;
        end
    end
endmodule

// ==== test/pin_mux_sva.sv ====
`timescale 1ns/1ns
module pin_mux_sva
    import pin_mux_pkg::*;
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // configuration and peripheral levels
    input wire port_cfg_type port2_cfg,
    input wire port_cfg_type port3_cfg,
    input wire port_cfg_type port4_cfg,
    input wire logic [7:0] timer2_edge_select,
    input wire logic [1:0] adc_mode_reg,
    input wire logic timer2_output,
    input wire logic [3:0] dma_terminal_count,
    input wire logic uart_transmit_ch1,
    input wire logic [1:0] serial_clock_oe,
    // device outputs
    input wire pad_drive_type port2_pad,
    input wire pad_drive_type port4_pad,
    input wire logic [3:0] ext_irq_12x,
    input wire logic adc_external_trigger,
    input wire logic [1:0] timer2_capture_edge,
    input wire logic [1:0] ext_irq_021_edge
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (rst);
    reset_idle_a: assert property ($fell(rst) |-> port2_pad == '0 && port4_pad == '0)
        else $error("pads driven after reset");
    gpio_mode_a: assert property (!$past(rst) |-> port4_pad.pad_oe[1] ==
        (!$past(port4_cfg.alt_function_enable[1]) && !$past(port4_cfg.pin_direction_bit[1])))
        else $error("pin direction wrong");
    timer_out_a: assert property (!$past(rst) && $past(port2_cfg.alt_function_enable[3])
        |-> port2_pad.pad_oe[3] && port2_pad.pad_out[3] == $past(timer2_output))
        else $error("timer output not on pin");
    dma_count_a: assert property (!$past(rst) && $past(port2_cfg.alt_function_enable[7])
        |-> port2_pad.pad_oe[7] == $past(port2_cfg.function_select[7]) &&
        (!port2_pad.pad_oe[7] || port2_pad.pad_out[7] == $past(dma_terminal_count[3])))
        else $error("dma count pin wrong");
    uart_tx_a: assert property (!$past(rst) && $past(port4_cfg.alt_function_enable[3]) &&
        $past(port4_cfg.function_select[3]) |-> port4_pad.pad_out[3] == $past(uart_transmit_ch1))
        else $error("uart transmit not on pin");
    sck_oe_a: assert property (!$past(rst) && $past(port4_cfg.alt_function_enable[5])
        |-> port4_pad.pad_oe[5] == $past(serial_clock_oe[1])) else $error("clock pin enable");
    unrouted_input_a: assert property (!$past(port3_cfg.alt_function_enable[5]) &&
        !$past(port3_cfg.alt_function_enable[5], 2) && !$past(port3_cfg.alt_function_enable[5], 3)
        |-> !ext_irq_12x[1]) else $error("unrouted input active");
    trigger_mode_a: assert property (adc_external_trigger |-> !ext_irq_12x[3] &&
        ($past(adc_mode_reg) == 2'h3 || $past(adc_mode_reg, 2) == 2'h3 ||
        $past(adc_mode_reg, 3) == 2'h3)) else $error("trigger outside trigger mode");
    edge_fwd_a: assert property (!$past(rst) |-> timer2_capture_edge ==
        $past(timer2_edge_select[5:4]) && ext_irq_021_edge == $past(timer2_edge_select[3:2]))
        else $error("edge field not forwarded");
endmodule

// ==== test/pin_world.sv ====
`timescale 1ns/1ns
module pin_world
    import pin_mux_pkg::*;
(
    // device pad drive
    input wire pad_drive_type port2_pad,
    input wire pad_drive_type port3_pad,
    input wire pad_drive_type port4_pad,
    // outside level on released pins
    input wire logic [23:0] ext_level,
    // resolved pin levels
    output logic [7:0] port2_pad_in,
    output logic [7:0] port3_pad_in,
    output logic [7:0] port4_pad_in
);
    // a driven pin shows the device value, a released one the outside level
    assign port2_pad_in = port2_pad.pad_out & port2_pad.pad_oe
        | ext_level[7:0] & ~port2_pad.pad_oe;
    assign port3_pad_in = port3_pad.pad_out & port3_pad.pad_oe
        | ext_level[15:8] & ~port3_pad.pad_oe;
    assign port4_pad_in = port4_pad.pad_out & port4_pad.pad_oe
        | ext_level[23:16] & ~port4_pad.pad_oe;
endmodule

// ==== test/testbench.sv ====
`timescale 1ns/1ns
module testbench;
    import pin_mux_pkg::*;
    logic core_clk, rst, timer2_output, serial_out_ch2, uart_transmit_ch2, serial_clock_ch2_out;
    logic serial_clock_ch2_oe, serial_out_ch0, uart_transmit_ch0;
    logic serial_out_ch1, uart_transmit_ch1;
    logic nmi_in, ext_irq_020, timer2_capture_input, ext_irq_021, adc_external_trigger;
    logic serial_in_ch2, serial_clock_ch2_in, uart_receive_ch2, serial_in_ch0, uart_receive_ch0;
    logic serial_in_ch1, uart_receive_ch1;
    logic [1:0] adc_mode_reg, serial_clock_out, serial_clock_oe, serial_clock_in;
    logic [1:0] ext_irq_020_edge, timer2_capture_edge, ext_irq_021_edge;
    logic [3:0] dma_terminal_count, ext_irq_11x, ext_irq_12x, ext_irq_13x;
    logic [7:0] irq_mode_reg_third, irq_mode_reg_fourth, irq_mode_reg_fifth, timer2_edge_select;
    logic [7:0] port2_pad_in, port3_pad_in, port4_pad_in;
    logic [7:0] ext_irq_11x_edge, ext_irq_12x_edge, ext_irq_13x_edge;
    logic [23:0] ext_level, port_read_level;
    port_cfg_type port2_cfg, port3_cfg, port4_cfg;
    pad_drive_type port2_pad, port3_pad, port4_pad;
    int n_mismatch = 0;
    int n_compared = 0;
    port_alternate_function_mux dut (.*);
    pin_world world (.*);
    initial begin
        core_clk = 1'b0;
        forever #25 core_clk = ~core_clk;
    end
    task automatic give_verdict();
        $display("compared %0d, mismatched %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic check_val(string what, logic [63:0] exp, logic [63:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask
    // pad output is only meaningful where the pin is driven
    task automatic check_pad(string what, logic [15:0] exp, pad_drive_type got);
        check_val(what, 64'({exp[15:8] & exp[7:0], exp[7:0]}),
            64'({got.pad_out & got.pad_oe, got.pad_oe}));
    endtask
    function automatic logic [15:0] exp_pad(port_cfg_type g, int p);
        logic [7:0] o, e;
        logic s;
        o = g.out_latch;
        e = ~g.pin_direction_bit & ~g.alt_function_enable;
        for (int i = 0; i < 8; i++) begin
            s = g.function_select[i];
            if (g.alt_function_enable[i]) begin
                case (p * 10 + i)
                    23: {o[i], e[i]} = {timer2_output, 1'b1};
                    24, 25, 26, 27: {o[i], e[i]} = {dma_terminal_count[i[1:0]], s};
                    30: {o[i], e[i]} = {serial_out_ch2, !s};
                    32: {o[i], e[i]} = {serial_clock_ch2_out, !s & serial_clock_ch2_oe};
                    33: {o[i], e[i]} = {uart_transmit_ch2, !s};
                    40: {o[i], e[i]} = {s ? uart_transmit_ch0 : serial_out_ch0, 1'b1};
                    42: {o[i], e[i]} = {serial_clock_out[0], serial_clock_oe[0]};
                    43: {o[i], e[i]} = {s ? uart_transmit_ch1 : serial_out_ch1, 1'b1};
                    45: {o[i], e[i]} = {serial_clock_out[1], serial_clock_oe[1]};
                    default: ;
                endcase
            end
        end
        return {o, e};
    endfunction
    task automatic check_all();
        logic [15:0] d2, d3, d4;
        logic [7:0] l2, l3, l4, c2, c3, c4, s2, s3, s4;
        logic t;
        repeat (6) @(negedge core_clk);
        d2 = exp_pad(port2_cfg, 2);
        d3 = exp_pad(port3_cfg, 3);
        d4 = exp_pad(port4_cfg, 4);
        l2 = d2[15:8] & d2[7:0] | ext_level[7:0] & ~d2[7:0];
        l3 = d3[15:8] & d3[7:0] | ext_level[15:8] & ~d3[7:0];
        l4 = d4[15:8] & d4[7:0] | ext_level[23:16] & ~d4[7:0];
        c2 = port2_cfg.alt_function_enable;
        c3 = port3_cfg.alt_function_enable;
        c4 = port4_cfg.alt_function_enable;
        s2 = port2_cfg.function_select;
        s3 = port3_cfg.function_select;
        s4 = port4_cfg.function_select;
        t = adc_mode_reg == 2'h3;
        check_pad("p2 pad", d2, port2_pad);
        check_pad("p3 pad", d3, port3_pad);
        check_pad("p4 pad", d4, port4_pad);
        check_val("levels", 64'({l4, l3, l2}), 64'(port_read_level));
        // both shared-pin routes follow the pin; software picks the use downstream
        check_val("shared pin", 64'({2{c2[1] & l2[1]}}),
            64'({ext_irq_020, timer2_capture_input}));
        check_val("port2 inputs", 64'({c2[0] & l2[0], c2[2] & l2[2],
            c2[7:4] & ~s2[7:4] & l2[7:4]}), 64'({nmi_in, ext_irq_021, ext_irq_11x}));
        check_val("port3 inputs", 64'({c3[7] & l3[7] & !t,
            c3[6:5] & l3[6:5], c3[4] & s3[4] & l3[4], c3[3:0] & s3[3:0] & l3[3:0],
            c3[7] & l3[7] & t, c3[1] & ~s3[1] & l3[1], c3[2] & ~s3[2] & l3[2],
            c3[4] & ~s3[4] & l3[4]}), 64'({ext_irq_12x, ext_irq_13x, adc_external_trigger,
            serial_in_ch2, serial_clock_ch2_in, uart_receive_ch2}));
        check_val("port4 inputs", 64'({c4[1] & ~s4[1] & l4[1],
            c4[1] & s4[1] & l4[1], c4[4] & ~s4[4] & l4[4], c4[4] & s4[4] & l4[4],
            c4[5] & l4[5], c4[2] & l4[2]}), 64'({serial_in_ch0, uart_receive_ch0,
            serial_in_ch1, uart_receive_ch1, serial_clock_in}));
        check_val("edges", 64'({timer2_edge_select[1:0],
            timer2_edge_select[5:4], timer2_edge_select[3:2], irq_mode_reg_third,
            irq_mode_reg_fourth, irq_mode_reg_fifth}),
            64'({ext_irq_020_edge, timer2_capture_edge, ext_irq_021_edge, ext_irq_11x_edge,
            ext_irq_12x_edge, ext_irq_13x_edge}));
    endtask
    task automatic check_idle();
        check_val("idle", 64'h0, 64'({port2_pad, port3_pad, port4_pad, ext_irq_12x}));
    endtask
    task automatic drive_random();
        port2_cfg = $urandom;
        port3_cfg = $urandom;
        port4_cfg = $urandom;
        port4_cfg.alt_function_enable[7:6] = 2'h0;
        {irq_mode_reg_third, irq_mode_reg_fourth, irq_mode_reg_fifth, timer2_edge_select} = $urandom;
        ext_level = 24'($urandom);
        {adc_mode_reg, timer2_output, dma_terminal_count, serial_out_ch2, uart_transmit_ch2,
            serial_clock_ch2_out, serial_clock_ch2_oe, serial_out_ch0, uart_transmit_ch0,
            serial_out_ch1, uart_transmit_ch1, serial_clock_out, serial_clock_oe} = 19'($urandom);
    endtask
    initial begin
        void'($urandom(32'h4daa_5bfe));
        rst = 1'b1;
        drive_random();
        repeat (11) @(negedge core_clk);
        check_idle();
        @(negedge core_clk);
        rst = 1'b0;
        $display("test reset done");
        // every select value and every converter mode with all port 2 and 3 pins and port 4 pins 0-5 in control mode
        for (int k = 0; k < 8; k++) begin
            drive_random();
            {port2_cfg.alt_function_enable, port3_cfg.alt_function_enable} = 16'hffff;
            port4_cfg.alt_function_enable = 8'h3f;
            {port2_cfg.function_select, port3_cfg.function_select} = {16{k[0]}};
            port4_cfg.function_select = {8{k[0]}};
            adc_mode_reg = k[2:1];
            check_all();
        end
        $display("test select codes done");
        for (int k = 0; k < 200; k++) begin
            drive_random();
            check_all();
            if (k == 100) begin
                rst = 1'b1;
                @(negedge core_clk);
                check_idle();
                rst = 1'b0;
            end
        end
        $display("test random mix done");
        give_verdict();
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        n_mismatch++;
        $display("BAD watchdog expected finish seen hang");
        give_verdict();
    end
endmodule
bind port_alternate_function_mux pin_mux_sva sva (.*);
